// File: logic/acr_pkg.sv
package acr_pkg;

  // Register geometry
  localparam int          ACR_WIDTH       = 16;
  localparam logic [15:0] ACR_RESET_VALUE = 16'h0300;

  // Field positions
  localparam int ACR_AUX_SEL_POS   = 1;
  localparam int ACR_RX_GAIN_POS   = 2;
  localparam int ACR_OVS_LSB       = 3;
  localparam int ACR_ATTEN_LSB     = 6;
  localparam int ACR_MDIV_LOW_POS  = 8;
  localparam int ACR_QDIV_LSB      = 9;
  localparam int ACR_MDIV_TEST_LSB = 12;
  localparam int ACR_RSVD_TEST_LSB = 14;

  // Oversampling ratio codes
  localparam logic [2:0] ACR_OVS_160 = 3'h0;
  localparam logic [2:0] ACR_OVS_192 = 3'h1;
  localparam logic [2:0] ACR_OVS_64  = 3'h5;
  localparam logic [2:0] ACR_OVS_96  = 3'h6;
  localparam logic [2:0] ACR_OVS_128 = 3'h7;

  // Transmit attenuation codes
  localparam logic [1:0] ACR_ATTEN_MUTE = 2'h0;
  localparam logic [1:0] ACR_ATTEN_M6DB = 2'h2;
  localparam logic [1:0] ACR_ATTEN_0DB  = 2'h3;

  // Host link mode
  typedef enum logic [1:0] {
    ACR_MODE_SW_DATA = 2'b00,
    ACR_MODE_SW_CTRL = 2'b01,
    ACR_MODE_HW_DATA = 2'b10,
    ACR_MODE_HW_CTRL = 2'b11
  } acr_mode_t;

  // Serial receive states
  typedef enum logic [1:0] {
    ACR_ST_IDLE    = 2'b00,
    ACR_ST_PRIMARY = 2'b01,
    ACR_ST_SECOND  = 2'b10
  } acr_state_t;

  // Decoded fields
  typedef struct packed {
    logic       aux_input_select;
    logic       rx_gain_select;
    logic [7:0] oversample_ratio;
    logic       ovs_reserved;
    logic [1:0] tx_atten;
    logic       tx_mute;
    logic       atten_reserved;
    logic [4:0] qdiv_x2;  // Twice Q; Q of 8 needs the fifth bit
    logic [2:0] mdiv;
    logic       mdiv_reserved;
    logic [1:0] test_mode;
  } acr_fields_t;

endpackage

// File: logic/acr_control_register.sv
`timescale 1ns/1ps
module acr_control_register
  import acr_pkg::*;
#(
  parameter int FRAME_BITS = 256
)
(
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                rst_n,
  // Mode straps
  input  wire logic                host_mode_pin0,
  input  wire logic                host_mode_pin1,
  input  wire logic                master_mode,
  input  wire logic                sw_lsb_ctrl,
  // Serial link, one bit per mclk
  input  wire logic                fs_in,
  input  wire logic                sdin,
  output logic                     fs_out,
  // Register contents and decodes
  output logic [15:0]              afe_control,
  output acr_pkg::acr_fields_t     fields,
  output logic                     control_mode,
  output logic                     word_loaded
);
  import acr_pkg::*;

  localparam int CW = $clog2(FRAME_BITS);

  acr_state_t      state;
  acr_state_t      next_state;
  logic [15:0]     shift;
  logic [15:0]     next_shift;
  logic [4:0]      bit_cnt;
  logic [4:0]      next_bit_cnt;
  logic [CW-1:0]   frame_cnt;
  logic [CW-1:0]   next_frame_cnt;
  logic            half_seen;
  logic            next_half_seen;
  logic            fs_gen;
  logic            next_fs_out;
  logic [15:0]     next_afe_control;
  logic            next_word_loaded;
  logic            next_control_mode;
  acr_fields_t     next_fields;
  acr_mode_t       mode;
  logic            frame_sync;
  logic            sw_data_word_ctrl;

  assign mode = acr_mode_t'({host_mode_pin1, host_mode_pin0});
  // Pin1 high is control; software data mode (pins 00) also needs the word LSB request
  assign sw_data_word_ctrl = (mode == ACR_MODE_SW_DATA) && sw_lsb_ctrl;

  // Sync source: own generator when master, else processor pulses
  assign frame_sync = master_mode ? fs_gen : fs_in;

  // Master frame timing; extra pulse at the half period in control mode
  always_comb
  begin
    next_frame_cnt = (frame_cnt == CW'(FRAME_BITS - 1)) ? '0 : frame_cnt + 1'b1;
    fs_gen         = (frame_cnt == '0) ||
                     (control_mode && frame_cnt == CW'(FRAME_BITS / 2));
    next_fs_out    = master_mode && fs_gen;
    // Control mode decided by the pins; data-only otherwise
    next_control_mode = host_mode_pin1 || sw_data_word_ctrl;
  end

  // Serial word capture, primary then secondary slot
  always_comb
  begin
    next_state       = state;
    next_shift       = shift;
    next_bit_cnt     = bit_cnt;
    next_half_seen   = half_seen;
    next_afe_control = afe_control;
    next_word_loaded = 1'b0;
    if (frame_sync)
    begin
      // Alternate pulses mark secondary slots only in control mode
      if (control_mode && half_seen)
      begin
        next_state     = ACR_ST_SECOND;
        next_half_seen = 1'b0;
      end
      else
      begin
        next_state     = ACR_ST_PRIMARY;
        next_half_seen = control_mode;
      end
      next_bit_cnt = 5'h00;
    end
    else if (state != ACR_ST_IDLE)
    begin
      next_shift   = {shift[14:0], sdin};
      next_bit_cnt = bit_cnt + 5'h01;
      if (bit_cnt == 5'h0F)
      begin
        next_state = ACR_ST_IDLE;
        // Primary words are data and never touch the register
        if (state == ACR_ST_SECOND && control_mode)
        begin
          next_afe_control = {shift[14:0], sdin};
          next_word_loaded = 1'b1;
        end
      end
    end
  end

  // Field decode from the next register value so outputs stay registered
  always_comb
  begin
    next_fields                  = '0;
    next_fields.aux_input_select = next_afe_control[ACR_AUX_SEL_POS];
    // Gain meaning depends on input wiring (diff vs single-ended)
    next_fields.rx_gain_select   = next_afe_control[ACR_RX_GAIN_POS];
    case (next_afe_control[ACR_OVS_LSB +: 3])
      ACR_OVS_160: next_fields.oversample_ratio = 8'd160;
      ACR_OVS_192: next_fields.oversample_ratio = 8'd192;
      ACR_OVS_64:  next_fields.oversample_ratio = 8'd64;
      ACR_OVS_96:  next_fields.oversample_ratio = 8'd96;
      ACR_OVS_128: next_fields.oversample_ratio = 8'd128;
      default:     next_fields.ovs_reserved     = 1'b1;
    endcase
    next_fields.tx_atten = next_afe_control[ACR_ATTEN_LSB +: 2];
    case (next_afe_control[ACR_ATTEN_LSB +: 2])
      ACR_ATTEN_MUTE: next_fields.tx_mute        = 1'b1;
      ACR_ATTEN_M6DB: next_fields.tx_mute        = 1'b0;
      ACR_ATTEN_0DB:  next_fields.tx_mute        = 1'b0;
      default:        next_fields.atten_reserved = 1'b1;
    endcase
    // Q held doubled so half steps stay integral: 5..8, then 4.5..7.5
    next_fields.qdiv_x2 = next_afe_control[ACR_QDIV_LSB + 2]
      ? 5'(9 + 2 * next_afe_control[ACR_QDIV_LSB +: 2])
      : 5'(10 + 2 * next_afe_control[ACR_QDIV_LSB +: 2]);
    case ({next_afe_control[ACR_MDIV_TEST_LSB +: 2],
           next_afe_control[ACR_MDIV_LOW_POS]})
      3'h0:    next_fields.mdiv = 3'h3;
      3'h1:    next_fields.mdiv = 3'h4;
      3'h6:    next_fields.mdiv = 3'h1;
      3'h7:    next_fields.mdiv = 3'h2;
      default: next_fields.mdiv_reserved = 1'b1;
    endcase
    next_fields.test_mode = next_afe_control[ACR_MDIV_TEST_LSB +: 2];
  end

  // Registers; reset lands in data-only with the documented word
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state        <= ACR_ST_IDLE;
      shift        <= 16'h0000;
      bit_cnt      <= 5'h00;
      frame_cnt    <= '0;
      half_seen    <= 1'b0;
      fs_out       <= 1'b0;
      afe_control  <= ACR_RESET_VALUE;
      fields       <= '{aux_input_select: 1'b0, rx_gain_select: 1'b0,
                        oversample_ratio: 8'd160, ovs_reserved: 1'b0,
                        tx_atten: 2'h0, tx_mute: 1'b1, atten_reserved: 1'b0,
                        qdiv_x2: 5'h0C, mdiv: 3'h4, mdiv_reserved: 1'b0,
                        test_mode: 2'h0};
      control_mode <= 1'b0;
      word_loaded  <= 1'b0;
    end
    else
    begin
      state        <= next_state;
      shift        <= next_shift;
      bit_cnt      <= next_bit_cnt;
      frame_cnt    <= next_frame_cnt;
      half_seen    <= next_half_seen;
      fs_out       <= next_fs_out;
      afe_control  <= next_afe_control;
      fields       <= next_fields;
      control_mode <= next_control_mode;
      word_loaded  <= next_word_loaded;
    end
  end

endmodule

// File: test/acr_control_register_sva.sv
`timescale 1ns/1ps
module acr_control_register_sva
  import acr_pkg::*;
(
  // Clock, reset and mode pins
  input wire logic                 mclk,
  input wire logic                 rst_n,
  input wire logic                 host_mode_pin0,
  input wire logic                 host_mode_pin1,
  input wire logic                 sw_lsb_ctrl,
  // Register and decodes
  input wire logic [15:0]          afe_control,
  input wire acr_pkg::acr_fields_t fields,
  input wire logic                 control_mode,
  input wire logic                 word_loaded
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Expected decodes; reserved ratio codes read as zero
  wire [2:0] ovs = afe_control[5:3];
  wire [2:0] qc = afe_control[11:9];
  wire [7:0] ovs_exp = ovs == 3'h0 ? 8'hA0 : ovs == 3'h1 ? 8'hC0 : ovs == 3'h5 ? 8'h40 :
                       ovs == 3'h6 ? 8'h60 : ovs == 3'h7 ? 8'h80 : 8'h00;
  wire       ctrl_sel = host_mode_pin1 | (!host_mode_pin0 & sw_lsb_ctrl);
  a_reset_value: assert property ($rose(rst_n) |-> afe_control == 16'h0300 && !control_mode)
    else $error("bad reset state");
  a_hold_between: assert property ($past(rst_n) && !word_loaded |-> $stable(afe_control))
    else $error("register moved without a load");
  a_load_pulse: assert property (word_loaded |=> !word_loaded)
    else $error("load pulse too long");
  a_mode_pins: assert property ($past(rst_n) |-> control_mode == $past(ctrl_sel))
    else $error("mode does not follow pins");
  a_ovs_decode: assert property (fields.oversample_ratio == ovs_exp
    && fields.ovs_reserved == (ovs_exp == 8'h00)) else $error("ratio decode");
  a_atten_decode: assert property (fields.tx_atten == afe_control[7:6] && fields.tx_mute ==
    (afe_control[7:6] == 2'h0) && fields.atten_reserved == (afe_control[7:6] == 2'h1))
    else $error("attenuation decode");
  a_qdiv_decode: assert property (
    fields.qdiv_x2 == (qc[2] ? 5'h09 : 5'h0A) + {2'h0, qc[1:0], 1'b0})
    else $error("Q decode");
  a_mdiv_decode: assert property (fields.test_mode == afe_control[13:12]
    && fields.mdiv_reserved == (afe_control[13] ^ afe_control[12]) && (fields.mdiv_reserved
    || fields.mdiv == (afe_control[13] ? 3'h1 : 3'h3) + {2'h0, afe_control[8]}))
    else $error("M decode");
  c_load: cover property (word_loaded);
  c_ctrl: cover property ($rose(control_mode));
  c_rsvd: cover property (fields.ovs_reserved);
endmodule
bind acr_control_register acr_control_register_sva u_sva (.mclk, .rst_n, .host_mode_pin0,
  .host_mode_pin1, .sw_lsb_ctrl, .afe_control, .fields, .control_mode, .word_loaded);

// File: test/acr_host_model.sv
`timescale 1ns/1ps
module acr_host_model
(
  // Serial link into the device
  input  wire logic mclk,
  output logic      fs_in,
  output logic      sdin
);
  initial
  begin
    fs_in = 1'b0;
    sdin  = 1'b0;
  end
  // Sync, then sixteen bits; idle line shows the inverted last bit, not a held value
  task automatic send(input logic [15:0] w);
    @(posedge mclk);
    fs_in <= 1'b1;
    for (int i = 15; i >= 0; i--)
    begin
      @(posedge mclk);
      fs_in <= 1'b0;
      sdin  <= w[i];
    end
    @(posedge mclk);
    sdin <= ~w[0];
  endtask
endmodule

// File: test/acr_control_register_tb_top.sv
`timescale 1ns/1ps
module acr_control_register_tb_top;
  import acr_pkg::*;
  logic        mclk, rst_n, host_mode_pin0, host_mode_pin1, master_mode, sw_lsb_ctrl;
  logic        fs_in, sdin, fs_out, control_mode, word_loaded, ctl;
  logic [15:0] afe_control, exp;
  acr_fields_t fields;
  int          fails, num_checks, n;
  acr_control_register #(.FRAME_BITS(64)) DUT (.mclk, .rst_n, .host_mode_pin0,
    .host_mode_pin1, .master_mode, .sw_lsb_ctrl, .fs_in, .sdin, .fs_out, .afe_control,
    .fields, .control_mode, .word_loaded);
  acr_host_model HOST (.mclk, .fs_in, .sdin);
  // Free-running 125 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // Count and report one comparison
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    num_checks++;
    if (got !== want)
    begin
      fails++;
      $display("Error %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic conclude;
    if (fails == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    exp = 16'h0300;
    @(negedge mclk);
    chk(afe_control, exp);
  endtask
  // Primary word then secondary word; only the second may land, and only in control mode
  task automatic frame(input logic [15:0] p, input logic [15:0] s);
    HOST.send(p);
    HOST.send(s);
    if (ctl)
      exp = s;
    repeat (3) @(negedge mclk);
    chk(afe_control, exp);
  endtask
  initial
  begin
    {rst_n, host_mode_pin0, host_mode_pin1, master_mode, sw_lsb_ctrl, ctl} = '0;
    void'($urandom(49));
    do_reset();
    chk({15'h0, control_mode}, 16'h0000);
    frame(16'hFFFF, 16'h3CFE);
    host_mode_pin0 <= 1'b1;
    frame(16'h1234, 16'h0ED6);
    host_mode_pin0 <= 1'b0;
    sw_lsb_ctrl <= 1'b1;
    ctl = 1'b1;
    for (int i = 0; i < 24; i++)
    begin
      if (i == 12)
        host_mode_pin1 <= 1'b1;
      frame(16'($urandom), (16'($urandom) & 16'h3FFF) | 16'h0004);
    end
    do_reset();
    frame(16'h0000, 16'h3FFE);
    // Master mode: sync spacing is half the shortened frame
    master_mode <= 1'b1;
    for (n = 0; fs_out !== 1'b1 && n < 99; n++)
      @(negedge mclk);
    chk({15'h0, fs_out}, 16'h0001);
    @(negedge mclk);
    for (n = 1; fs_out !== 1'b1 && n < 99; n++)
      @(negedge mclk);
    chk(16'(n), 16'h0020);
    conclude();
  end
endmodule
